// ---- lcd_ram_loader_pkg.sv ----
/*
  constants for the lcd display ram loader: bus pattern, control byte
  codes, memory geometry, pointer behaviour and scan timing.
  assumes a 200 MHz system clock.
*/
package lcd_ram_loader_pkg;
  localparam int COLS = 44;
  localparam int ROWS = 4;
  localparam int PTR_W = 6;
  localparam logic [PTR_W-1:0] PTR_RST = 6'h00;
  localparam logic [PTR_W-1:0] PTR_END = 6'h2C;
  localparam logic [6:0] PTR_STEP = 7'h02;
  localparam logic [5:0] ADDR_PATTERN = 6'h1C;
  localparam int CO_BIT = 7;
  localparam int SEL_HI = 6;
  localparam int SEL_LO = 5;
  localparam logic [1:0] SEL_CMD = 2'h0;
  localparam logic [1:0] SEL_RAM = 2'h1;
  localparam logic [3:0] BITS_BYTE = 4'h8;
  localparam logic [3:0] BITS_ACK = 4'h9;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_WIDTH = 9;
  localparam int CLK_PERIOD_NS = 5;
  localparam int ROW_TIME_NS = 1000000;
  localparam int ROW_CYCLES = ROW_TIME_NS / CLK_PERIOD_NS;
endpackage : lcd_ram_loader_pkg

// ---- lcd_display_ram_loader.sv ----
/*
  i2c target write path, byte fifo, 44 x 4 display ram with auto
  incrementing pointer, display register and row scan outputs.
  assumes scl/sda/address select arrive asynchronously; pointer load
  comes from an external command decoder on clk_i.
*/
`timescale 1ns/10ps

module lcd_byte_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0] wr_ff;
  logic [AW:0] rd_ff;
  wire full = (wr_ff[AW-1:0] == rd_ff[AW-1:0]) && (wr_ff[AW] != rd_ff[AW]);
  wire empty = (wr_ff == rd_ff);
  wire push = in_valid_i && !full;
  wire pop = out_ready_i && !empty;

  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = mem_ff[rd_ff[AW-1:0]];

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_ff[wr_ff[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ff <= '0;
      rd_ff <= '0;
    end else begin
      if (push) wr_ff <= wr_ff + 1'b1;
      if (pop) rd_ff <= rd_ff + 1'b1;
    end
  end
endmodule : lcd_byte_fifo

module lcd_display_ram_loader #(
  parameter int ROW_DIV = lcd_ram_loader_pkg::ROW_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // i2c pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic address_select_pin_i,
  // command decoder side
  output logic [7:0] cmd_data_o,
  output logic cmd_valid_o,
  input wire logic cmd_ready_i,
  input wire logic ptr_load_i,
  input wire logic [lcd_ram_loader_pkg::PTR_W-1:0] ptr_value_i,
  // lcd drive
  output logic [lcd_ram_loader_pkg::ROWS-1:0] backplane_outputs_o,
  output logic [lcd_ram_loader_pkg::COLS-1:0] segment_outputs_o
);
  import lcd_ram_loader_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_CTRL, ST_DATA, ST_IGNORE} link_state_type;
  localparam int DW = $clog2(ROW_DIV);

  link_state_type state_ff, nxt_state;
  logic [1:0] scl_sync_ff, sda_sync_ff, sel_sync_ff;
  logic scl_d_ff, sda_d_ff;
  logic [3:0] cnt_ff;
  logic [7:0] shift_ff;
  logic ack_ff, continue_flag_ff;
  logic [1:0] register_select_ff;
  logic [PTR_W-1:0] ptr_ff, nxt_ptr;
  logic [3:0] ram_ff [COLS];
  logic [3:0] disp_ff [COLS];
  logic [DW-1:0] div_ff;
  logic [1:0] row_ff;
  logic fifo_in_ready, fifo_valid, fifo_out_ready;
  logic [FIFO_WIDTH-1:0] fifo_data;

  // pin sampling and bus events
  wire scl_s = scl_sync_ff[1];
  wire sda_s = sda_sync_ff[1];
  wire sel_s = sel_sync_ff[1];
  wire scl_rise = scl_s && !scl_d_ff;
  wire scl_fall = !scl_s && scl_d_ff;
  wire start_det = scl_s && scl_d_ff && sda_d_ff && !sda_s;
  wire stop_det = scl_s && scl_d_ff && !sda_d_ff && sda_s;
  wire in_byte = (state_ff == ST_ADDR) || (state_ff == ST_CTRL) || (state_ff == ST_DATA);
  wire byte_done = scl_fall && (cnt_ff == BITS_BYTE) && in_byte;
  wire addr_match = (shift_ff[7:2] == ADDR_PATTERN) && (shift_ff[1] == sel_s);
  wire is_write = !shift_ff[0];
  wire sel_known = (register_select_ff == SEL_CMD) || (register_select_ff == SEL_RAM);
  wire push = byte_done && (state_ff == ST_DATA) && sel_known;
  wire give_ack = byte_done && ((state_ff == ST_ADDR) ? addr_match : !(push && !fifo_in_ready));

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      scl_sync_ff <= 2'h3;
      sda_sync_ff <= 2'h3;
      sel_sync_ff <= 2'h0;
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_sync_ff <= {scl_sync_ff[0], scl_i};
      sda_sync_ff <= {sda_sync_ff[0], sda_i};
      sel_sync_ff <= {sel_sync_ff[0], address_select_pin_i};
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE, ST_IGNORE: nxt_state = state_ff;
      ST_ADDR: if (byte_done) nxt_state = !addr_match ? ST_IGNORE : is_write ? ST_CTRL : ST_IGNORE;
      ST_CTRL: if (byte_done) nxt_state = ST_DATA;
      ST_DATA: if (byte_done && continue_flag_ff) nxt_state = ST_CTRL;
    endcase
    if (start_det) nxt_state = ST_ADDR;
    else if (stop_det) nxt_state = ST_IDLE;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      ack_ff <= 1'b0;
      continue_flag_ff <= 1'b0;
      register_select_ff <= SEL_CMD;
    end else begin
      state_ff <= nxt_state;
      if (start_det || stop_det) begin
        cnt_ff <= 4'h0;
        ack_ff <= 1'b0;
      end else if (scl_rise && cnt_ff < BITS_BYTE) begin
        shift_ff <= {shift_ff[6:0], sda_s};
        cnt_ff <= cnt_ff + 4'h1;
      end else if (scl_rise && cnt_ff == BITS_BYTE) begin
        cnt_ff <= BITS_ACK;
      end else if (scl_fall && cnt_ff == BITS_ACK) begin
        cnt_ff <= 4'h0;
        ack_ff <= 1'b0;
      end else if (byte_done) begin
        ack_ff <= give_ack;
      end
      if (byte_done && state_ff == ST_CTRL) begin
        continue_flag_ff <= shift_ff[CO_BIT];
        register_select_ff <= shift_ff[SEL_HI:SEL_LO];
      end
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_o = ack_ff;

  lcd_byte_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .in_valid_i(push),
    .in_ready_o(fifo_in_ready),
    .in_data_i({register_select_ff == SEL_RAM, shift_ff}),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_out_ready),
    .out_data_o(fifo_data)
  );

  wire head_ram = fifo_data[8];
  assign cmd_valid_o = fifo_valid && !head_ram;
  assign cmd_data_o = fifo_data[7:0];
  assign fifo_out_ready = head_ram ? !ptr_load_i : cmd_ready_i;
  wire ram_wr = fifo_valid && head_ram && !ptr_load_i;

  // advance by two, clamp at end
  wire [6:0] ptr_sum = {1'b0, ptr_ff} + PTR_STEP;
  wire [6:0] ptr_plus1 = {1'b0, ptr_ff} + 7'h01;
  wire [PTR_W-1:0] ptr_adv = (ptr_sum > {1'b0, PTR_END}) ? PTR_END : ptr_sum[PTR_W-1:0];
  assign nxt_ptr = ptr_load_i ? ptr_value_i : ram_wr ? ptr_adv : ptr_ff;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ptr_ff <= PTR_RST;
    end else begin
      ptr_ff <= nxt_ptr;
    end
  end

  // row scan divider
  wire row_tick = (div_ff == DW'(ROW_DIV - 1));
  wire [1:0] nxt_row = row_ff + 2'h1;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_ff <= '0;
      row_ff <= 2'h0;
      backplane_outputs_o <= 4'h1;
    end else begin
      div_ff <= row_tick ? '0 : div_ff + 1'b1;
      if (row_tick) begin
        row_ff <= nxt_row;
        backplane_outputs_o <= 4'h1 << nxt_row;
      end
    end
  end

  // ram columns, no reset on ram
  for (genvar c = 0; c < COLS; c++) begin : g_col
    localparam logic [6:0] CI = 7'(c);
    // high nibble first, two columns, overflow dropped
    wire hit_hi = ram_wr && ({1'b0, ptr_ff} == CI);
    wire hit_lo = ram_wr && (ptr_plus1 == CI);
    always_ff @(posedge clk_i) begin
      if (hit_hi) ram_ff[c] <= fifo_data[7:4];
      else if (hit_lo) ram_ff[c] <= fifo_data[3:0];
    end
    always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        disp_ff[c] <= 4'h0;
        segment_outputs_o[c] <= 1'b0;
      end else if (row_tick) begin
        if (nxt_row == 2'h0) disp_ff[c] <= ram_ff[c];
        segment_outputs_o[c] <= (nxt_row == 2'h0) ? ram_ff[c][0] : disp_ff[c][nxt_row];
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  a_ptr_advance: assert property (ram_wr && ptr_ff < 6'h2B |=> ptr_ff == $past(ptr_ff) + 6'h02)
    else $error("pointer did not advance by two");
  a_ptr_stop: assert property (ptr_ff == PTR_END && !ptr_load_i |=> ptr_ff == PTR_END)
    else $error("pointer moved past end");
  a_ptr_load: assert property (ptr_load_i |=> ptr_ff == $past(ptr_value_i))
    else $error("pointer load lost");
  a_ram_nibble: assert property (ram_wr && ptr_ff < PTR_END |=> ram_ff[$past(ptr_ff)] == $past(fifo_data[7:4]))
    else $error("upper nibble not stored");
  a_ack_timing: assert property (byte_done && state_ff == ST_CTRL |=> sda_oe_o)
    else $error("control byte not acknowledged");
  a_ack_hold: assert property (sda_oe_o && !scl_fall && !start_det && !stop_det |=> sda_oe_o)
    else $error("acknowledge dropped early");
  a_ignore_other: assert property (byte_done && state_ff == ST_ADDR && !addr_match && !start_det && !stop_det |=> state_ff == ST_IGNORE ##1 !sda_oe_o)
    else $error("foreign address not ignored");
  a_start_addr: assert property (start_det |=> state_ff == ST_ADDR && cnt_ff == 4'h0)
    else $error("start not seen");
  a_stop_idle: assert property (stop_det |=> state_ff == ST_IDLE && !sda_oe_o)
    else $error("stop not seen");
  a_ctrl_next: assert property (byte_done && state_ff == ST_DATA && continue_flag_ff && !start_det && !stop_det |=> state_ff == ST_CTRL)
    else $error("continue flag ignored");
  a_cmd_route: assert property (cmd_valid_o && !cmd_ready_i |=> cmd_valid_o && $stable(cmd_data_o))
    else $error("command byte dropped");
  a_bp_onehot: assert property ($onehot(backplane_outputs_o))
    else $error("backplane not one-hot");
endmodule : lcd_display_ram_loader

// ---- lcd_i2c_host_model.sv ----
/*
  i2c controller model driving a write-only target.
  assumes the bench forms sda as the and of host and target drive, with no pull-up.
*/
`timescale 1ns/10ps
module lcd_i2c_host_model (
  // clock
  input wire logic clk_i,
  // bus
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic w(input int n);
    repeat (n) @(negedge clk_i);
  endtask : w
  task automatic start();
    sda_o = 1'b1;
    w(4);
    scl_o = 1'b1;
    w(8);
    sda_o = 1'b0;
    w(8);
    scl_o = 1'b0;
    w(4);
  endtask : start
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_o = b[i];
      w(4);
      scl_o = 1'b1;
      w(8);
      scl_o = 1'b0;
      w(4);
    end
    sda_o = 1'b1;
    w(4);
    scl_o = 1'b1;
    w(1);
    ack = ~sda_i;
    w(6);
    ack = ack & ~sda_i;
    w(1);
    scl_o = 1'b0;
    w(4);
  endtask : send_byte
  task automatic stop();
    sda_o = 1'b0;
    w(4);
    scl_o = 1'b1;
    w(8);
    sda_o = 1'b1;
    w(8);
  endtask : stop
endmodule : lcd_i2c_host_model

// ---- lcd_display_ram_loader_tb.sv ----
/*
  self-checking bench for the display ram loader.
  assumes the host model above and a short row period.
*/
`timescale 1ns/10ps
module lcd_display_ram_loader_tb;
  import lcd_ram_loader_pkg::*;
  localparam int RD = 16;
  logic clk_i = 0, rst_b_i = 0, cmd_ready_i = 0, ptr_load_i = 0;
  logic address_select_pin_i = 1'b1;
  logic [PTR_W-1:0] ptr_value_i = '0;
  logic sda_o, sda_oe_o, cmd_valid_o, ack;
  logic [7:0] cmd_data_o;
  logic [ROWS-1:0] backplane_outputs_o;
  logic [COLS-1:0] segment_outputs_o;
  logic [3:0] exp_ram [0:COLS-1];
  wire scl, hsda, sda_line;
  int err_total = 0, tests_run = 0;
  assign sda_line = sda_oe_o ? (sda_o & hsda) : hsda;
  lcd_i2c_host_model u_host (.clk_i(clk_i), .sda_i(sda_line), .scl_o(scl), .sda_o(hsda));
  lcd_display_ram_loader #(.ROW_DIV(RD)) u_dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .address_select_pin_i(address_select_pin_i), .cmd_data_o(cmd_data_o),
    .cmd_valid_o(cmd_valid_o),
    .cmd_ready_i(cmd_ready_i), .ptr_load_i(ptr_load_i), .ptr_value_i(ptr_value_i),
    .backplane_outputs_o(backplane_outputs_o), .segment_outputs_o(segment_outputs_o));
  initial forever #2.5 clk_i = ~clk_i;
  task automatic chk(string n, logic [63:0] e, logic [63:0] s);
    tests_run++;
    if (s !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, s);
      err_total++;
    end
  endtask : chk
  task automatic sb(logic [7:0] b, logic e);
    u_host.send_byte(b, ack);
    chk("ack", 64'(e), 64'(ack));
  endtask : sb
  task automatic ld_ptr(logic [PTR_W-1:0] p);
    @(negedge clk_i) ptr_value_i = p;
    ptr_load_i = 1'b1;
    @(negedge clk_i) ptr_load_i = 1'b0;
  endtask : ld_ptr
  task automatic chk_disp();
    logic [COLS-1:0] e;
    int n;
    repeat (RD * 8 + 4) @(negedge clk_i);
    for (int r = 0; r < ROWS; r++) begin
      n = 0;
      while (backplane_outputs_o !== 4'(1 << r) && n < 200) begin
        @(negedge clk_i);
        n++;
      end
      for (int c = 0; c < COLS; c++) e[c] = exp_ram[c][r];
      chk("segments", 64'(e), 64'(segment_outputs_o));
    end
  endtask : chk_disp
  task automatic t_fill();
    logic [7:0] b;
    ld_ptr(6'h00);
    u_host.start();
    sb(8'h72, 1'b1);
    sb(8'h20, 1'b1);
    for (int k = 0; k < 23; k++) begin
      b = 8'(k * 11 + 97);
      sb(b, 1'b1);
      if (k < 22) begin
        exp_ram[2 * k] = b[7:4];
        exp_ram[2 * k + 1] = b[3:0];
      end
    end
    u_host.stop();
    chk_disp();
    $display("test fill done");
  endtask : t_fill
  task automatic t_edge();
    ld_ptr(6'h2B);
    u_host.start();
    sb(8'h72, 1'b1);
    sb(8'h20, 1'b1);
    sb(8'h3C, 1'b1);
    sb(8'hFF, 1'b1);
    u_host.stop();
    exp_ram[43] = 4'h3;
    chk_disp();
    $display("test edge done");
  endtask : t_edge
  task automatic t_mixed();
    ld_ptr(6'h02);
    u_host.start();
    sb(8'h72, 1'b1);
    sb(8'hC0, 1'b1);
    sb(8'hFF, 1'b1);
    sb(8'h80, 1'b1);
    sb(8'h5A, 1'b1);
    sb(8'h20, 1'b1);
    sb(8'h11, 1'b1);
    u_host.stop();
    chk("cmd_valid", 64'h1, 64'(cmd_valid_o));
    chk("cmd_data", 64'h5A, 64'(cmd_data_o));
    cmd_ready_i = 1'b1;
    @(negedge clk_i) cmd_ready_i = 1'b0;
    exp_ram[2] = 4'h1;
    exp_ram[3] = 4'h1;
    chk_disp();
    $display("test mixed done");
  endtask : t_mixed
  task automatic t_full();
    u_host.start();
    sb(8'h72, 1'b1);
    sb(8'h00, 1'b1);
    for (int k = 0; k < 9; k++) sb(8'hC0 + 8'(k), k < 8);
    u_host.stop();
    for (int k = 0; k < 8; k++) begin
      chk("cmd_valid", 64'h1, 64'(cmd_valid_o));
      chk("cmd_data", 64'hC0 + 64'(k), 64'(cmd_data_o));
      cmd_ready_i = 1'b1;
      @(negedge clk_i);
    end
    cmd_ready_i = 1'b0;
    chk("cmd_valid", 64'h0, 64'(cmd_valid_o));
    $display("test full done");
  endtask : t_full
  task automatic t_wrong();
    u_host.start();
    sb(8'h70, 1'b0);
    sb(8'h00, 1'b0);
    sb(8'h77, 1'b0);
    u_host.stop();
    chk("cmd_valid", 64'h0, 64'(cmd_valid_o));
    u_host.start();
    sb(8'h73, 1'b1);
    sb(8'h00, 1'b0);
    u_host.stop();
    chk("cmd_valid", 64'h0, 64'(cmd_valid_o));
    address_select_pin_i = 1'b0;
    u_host.start();
    sb(8'h72, 1'b0);
    sb(8'h00, 1'b0);
    u_host.stop();
    u_host.start();
    sb(8'h70, 1'b1);
    sb(8'h00, 1'b1);
    sb(8'h77, 1'b1);
    u_host.stop();
    chk("cmd_valid", 64'h1, 64'(cmd_valid_o));
    chk("cmd_data", 64'h77, 64'(cmd_data_o));
    cmd_ready_i = 1'b1;
    @(negedge clk_i) cmd_ready_i = 1'b0;
    address_select_pin_i = 1'b1;
    $display("test wrong address done");
  endtask : t_wrong
  task automatic t_reset();
    @(negedge clk_i) rst_b_i = 1'b0;
    repeat (3) @(negedge clk_i);
    chk("backplane", 64'h1, 64'(backplane_outputs_o));
    chk("segments", 64'h0, 64'(segment_outputs_o));
    rst_b_i = 1'b1;
    chk_disp();
    $display("test reset done");
  endtask : t_reset
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  initial begin
    #200000;
    err_total++;
    stop_test();
  end
  initial begin
    repeat (20) @(negedge clk_i);
    rst_b_i = 1'b1;
    repeat (5) @(negedge clk_i);
    t_fill();
    t_edge();
    t_mixed();
    t_full();
    t_wrong();
    t_reset();
    stop_test();
  end
endmodule : lcd_display_ram_loader_tb
